// ==== logic/urxbs_pkg.sv ====
`default_nettype none
package urxbs_pkg;

  // receive buffer geometry
  localparam int URXBS_DEPTH = 2;
  localparam int URXBS_ENTRY_W = 12;

  // field positions inside one buffer entry
  localparam int URXBS_DATA_LSB = 0;
  localparam int URXBS_DATA_W = 9;
  localparam int URXBS_NINTH_POS = 8;
  localparam int URXBS_UPE_POS = 9;
  localparam int URXBS_DOR_POS = 10;
  localparam int URXBS_FE_POS = 11;

  // character size codes
  localparam logic [2:0] URXBS_SIZE_5 = 3'h0;
  localparam logic [2:0] URXBS_SIZE_6 = 3'h1;
  localparam logic [2:0] URXBS_SIZE_7 = 3'h2;
  localparam logic [2:0] URXBS_SIZE_8 = 3'h3;
  localparam logic [2:0] URXBS_SIZE_9 = 3'h7;

  // data masks per character size
  localparam logic [8:0] URXBS_MASK_5 = 9'h01F;
  localparam logic [8:0] URXBS_MASK_6 = 9'h03F;
  localparam logic [8:0] URXBS_MASK_7 = 9'h07F;
  localparam logic [8:0] URXBS_MASK_8 = 9'h0FF;
  localparam logic [8:0] URXBS_MASK_9 = 9'h1FF;

  // reset values
  localparam logic [URXBS_ENTRY_W-1:0] URXBS_ENTRY_RST = 12'h000;

  typedef enum logic [0:0] {
    URXBS_IDLE = 1'b0,
    URXBS_RECV = 1'b1
  } urxbs_rx_e;

endpackage
`default_nettype wire

// ==== logic/urxbs_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
module urxbs_mem
  import urxbs_pkg::*;
#(
  parameter int WIDTH = URXBS_ENTRY_W,
  parameter int DEPTH = URXBS_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // read port, registered
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  // bypass so a frame written into the head slot is readable right away
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= WIDTH'(URXBS_ENTRY_RST);
    end else if (wr_en_i && (wr_addr_i == rd_addr_i)) begin
      rd_data_o <= wr_data_i;
    end else begin
      rd_data_o <= mem_r[rd_addr_i];
    end
  end

endmodule
`default_nettype wire

// ==== logic/urxbs_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module urxbs_top
  import urxbs_pkg::*;
#(
  parameter int DEPTH = URXBS_DEPTH
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // control bits
  input wire logic rx_enable_bit_i,
  input wire logic rx_complete_irq_enable_i,
  input wire logic global_irq_enable_i,
  input wire logic parity_mode_high_bit_i,
  input wire logic parity_mode_low_bit_i,
  input wire logic [2:0] char_size_i,
  // from the data recovery unit
  input wire logic start_detect_i,
  input wire logic frame_done_i,
  input wire logic [8:0] frame_data_i,
  input wire logic frame_parity_i,
  input wire logic frame_stop_i,
  // processor side
  input wire logic data_read_i,
  // status and data
  output logic rx_complete_flag_o,
  output logic frame_error_flag_o,
  output logic overrun_flag_o,
  output logic parity_error_flag_o,
  output logic [7:0] serial_data_o,
  output logic rx_ninth_bit_o,
  // interrupt and pin control
  output logic rx_irq_o,
  output logic rx_pin_override_o
);

  // pointers wrap naturally, so DEPTH must be a power of two
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    urxbs_rx_e rx_state;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
    logic hold_valid;
    logic [URXBS_ENTRY_W-1:0] hold_entry;
    logic lost;
    logic flag;
    logic irq;
    logic override;
  } urxbs_state_s;

  urxbs_state_s st_r;
  urxbs_state_s st_nxt;

  logic pop;
  logic space;
  logic frame_in;
  logic overrun_now;
  logic wr_en;
  logic [URXBS_ENTRY_W-1:0] wr_entry;
  logic [URXBS_ENTRY_W-1:0] new_entry;
  logic [URXBS_ENTRY_W-1:0] head_entry;
  logic irq_gate;

  function automatic logic [8:0] urxbs_mask(input logic [8:0] d, input logic [2:0] sz);
    logic [8:0] m;
    m = URXBS_MASK_8;
    case (sz)
      URXBS_SIZE_5: m = URXBS_MASK_5;
      URXBS_SIZE_6: m = URXBS_MASK_6;
      URXBS_SIZE_7: m = URXBS_MASK_7;
      URXBS_SIZE_8: m = URXBS_MASK_8;
      URXBS_SIZE_9: m = URXBS_MASK_9;
      default: m = URXBS_MASK_8;
    endcase
    return d & m;
  endfunction

  // entry for a frame finishing now; overrun bit is filled in on transfer
  function automatic logic [URXBS_ENTRY_W-1:0] urxbs_build(
    input logic [8:0] d, input logic [2:0] sz, input logic pb, input logic stop,
    input logic pm_hi, input logic pm_lo);
    logic [URXBS_ENTRY_W-1:0] e;
    logic [8:0] md;
    e = URXBS_ENTRY_RST;
    md = urxbs_mask(d, sz);
    e[URXBS_DATA_LSB +: URXBS_DATA_W] = md;
    e[URXBS_FE_POS] = ~stop;
    e[URXBS_UPE_POS] = pm_hi & ((^md) ^ pb ^ pm_lo);
    return e;
  endfunction

  assign irq_gate = rx_complete_irq_enable_i && global_irq_enable_i;

  always_comb begin
    st_nxt = st_r;
    pop = 1'b0;
    space = 1'b0;
    frame_in = 1'b0;
    overrun_now = 1'b0;
    wr_en = 1'b0;
    wr_entry = st_r.hold_entry;
    new_entry = urxbs_build(frame_data_i, char_size_i, frame_parity_i, frame_stop_i,
                            parity_mode_high_bit_i, parity_mode_low_bit_i);
    if (!rx_enable_bit_i) begin
      // immediate stop: ongoing frame, waiting character and buffer all dropped
      st_nxt.rx_state = URXBS_IDLE;
      st_nxt.wptr = '0;
      st_nxt.rptr = '0;
      st_nxt.count = '0;
      st_nxt.hold_valid = 1'b0;
      st_nxt.lost = 1'b0;
    end else begin
      pop = data_read_i && (st_r.count != '0);
      space = (st_r.count < CW'(DEPTH)) || pop;
      case (st_r.rx_state)
        URXBS_IDLE: begin
          if (start_detect_i) begin
            st_nxt.rx_state = URXBS_RECV;
            overrun_now = (st_r.count == CW'(DEPTH)) && st_r.hold_valid;
          end
        end
        URXBS_RECV: begin
          if (frame_done_i) begin
            st_nxt.rx_state = URXBS_IDLE;
            frame_in = 1'b1;
          end
        end
        default: begin
          st_nxt.rx_state = URXBS_IDLE;
        end
      endcase
      if (st_r.hold_valid && space) begin
        // waiting character moves first, a finishing frame takes its place
        wr_en = 1'b1;
        wr_entry = st_r.hold_entry;
        wr_entry[URXBS_DOR_POS] = st_r.lost;
        st_nxt.lost = 1'b0;
        st_nxt.hold_valid = frame_in;
        if (frame_in) begin
          st_nxt.hold_entry = new_entry;
        end
      end else if (frame_in) begin
        if (space) begin
          wr_en = 1'b1;
          wr_entry = new_entry;
          wr_entry[URXBS_DOR_POS] = st_r.lost;
          st_nxt.lost = 1'b0;
        end else begin
          // shifter content is overwritten; the lost mark survives
          st_nxt.hold_valid = 1'b1;
          st_nxt.hold_entry = new_entry;
        end
      end
      if (overrun_now) begin
        st_nxt.lost = 1'b1;
      end
      if (wr_en) begin
        st_nxt.wptr = st_r.wptr + AW'(1);
      end
      if (pop) begin
        st_nxt.rptr = st_r.rptr + AW'(1);
      end
      st_nxt.count = st_r.count + CW'(wr_en) - CW'(pop);
    end
    st_nxt.flag = (st_nxt.count != '0);
    // only the completion flag reaches the interrupt line
    st_nxt.irq = st_nxt.flag && irq_gate;
    st_nxt.override = rx_enable_bit_i;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // read address follows the next head so outputs show the readable entry
  urxbs_mem #(
    .WIDTH(URXBS_ENTRY_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_en_i(wr_en),
    .wr_addr_i(st_r.wptr),
    .wr_data_i(wr_entry),
    .rd_addr_i(st_nxt.rptr),
    .rd_data_o(head_entry)
  );

  // flags come from the buffer alone, so software writes cannot reach them
  assign frame_error_flag_o = head_entry[URXBS_FE_POS];
  assign overrun_flag_o = head_entry[URXBS_DOR_POS];
  assign parity_error_flag_o = head_entry[URXBS_UPE_POS];
  assign serial_data_o = head_entry[URXBS_DATA_LSB +: 8];
  assign rx_ninth_bit_o = head_entry[URXBS_NINTH_POS];
  assign rx_complete_flag_o = st_r.flag;
  assign rx_irq_o = st_r.irq;
  assign rx_pin_override_o = st_r.override;

  default clocking urxbs_cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  flag_count_a: assert property (rx_complete_flag_o == (st_r.count != '0))
    else $error("complete flag disagrees with buffer fill");

  flush_a: assert property (!rx_enable_bit_i |=> !rx_complete_flag_o && st_r.count == '0)
    else $error("disable did not flush buffer");

  irq_follow_a: assert property (rx_irq_o == (rx_complete_flag_o && $past(irq_gate)))
    else $error("interrupt does not follow flag and enables");

  pop_last_a: assert property ((st_r.count == CW'(1)) && data_read_i && !wr_en && rx_enable_bit_i
                               |=> !rx_complete_flag_o)
    else $error("read of last entry left flag set");

  pop_step_a: assert property (rx_enable_bit_i && data_read_i && (st_r.count != '0)
                               |=> st_r.rptr == $past(st_r.rptr) + AW'(1))
    else $error("read did not advance the buffer");

  irq_flag_only_a: assert property (rx_irq_o |-> rx_complete_flag_o)
    else $error("interrupt raised without completion flag");

  fe_stop_a: assert property (frame_done_i |-> new_entry[URXBS_FE_POS] == !frame_stop_i)
    else $error("frame error not inverse of stop bit");

  overrun_set_a: assert property (rx_enable_bit_i && st_r.rx_state == URXBS_IDLE && start_detect_i
                                  && st_r.hold_valid && st_r.count == CW'(DEPTH) |=> st_r.lost)
    else $error("overrun not detected");

  overrun_clear_a: assert property (wr_en && !overrun_now |=> !st_r.lost)
    else $error("lost mark survived a transfer");

  parity_off_a: assert property (!parity_mode_high_bit_i && frame_done_i
                                 |-> !new_entry[URXBS_UPE_POS])
    else $error("parity error while checking disabled");

  stop_recv_a: assert property (!rx_enable_bit_i |=> st_r.rx_state == URXBS_IDLE
                                && !st_r.hold_valid ##1 !wr_en || rx_enable_bit_i)
    else $error("reception continued after disable");

  pin_release_a: assert property ($fell(rx_enable_bit_i) |=> !rx_pin_override_o)
    else $error("receive pin still overridden");

  ninth_keep_a: assert property (frame_done_i && char_size_i == URXBS_SIZE_9
                                 |-> new_entry[URXBS_NINTH_POS] == frame_data_i[8])
    else $error("ninth bit not kept");

  mask_a: assert property (frame_done_i && char_size_i == URXBS_SIZE_5
                           |-> new_entry[8:5] == 4'h0)
    else $error("unused data bits not zero");

  upper_zero_a: assert property (frame_done_i && char_size_i == URXBS_SIZE_8
                                 |-> !new_entry[URXBS_NINTH_POS])
    else $error("ninth bit set in an eight bit frame");

  depth_a: assert property (st_r.count <= CW'(DEPTH))
    else $error("buffer count beyond depth");

  frame_store_a: assert property (rx_enable_bit_i && st_r.rx_state == URXBS_RECV && frame_done_i
                                  && !st_r.hold_valid && st_r.count != CW'(DEPTH) |-> wr_en)
    else $error("completed frame not written to buffer");

  full_c: cover property (st_r.count == CW'(DEPTH) && st_r.hold_valid);
  overrun_c: cover property (overrun_now ##[1:200] wr_en);
  irq_c: cover property (rx_irq_o ##1 data_read_i);
  parity_c: cover property (frame_done_i && new_entry[URXBS_UPE_POS]);

endmodule
`default_nettype wire

// ==== bench/urxbs_far_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module urxbs_far_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // frame request from the bench
  input wire logic send_i,
  input wire logic [8:0] data_i,
  input wire logic parity_i,
  input wire logic stop_i,
  // recovered frame towards the receiver
  output logic start_o,
  output logic done_o,
  output logic [8:0] data_o,
  output logic parity_o,
  output logic stop_o
);
  logic [3:0] cnt_r;
  logic [10:0] hold_r;
  // start always precedes done; lines toggle outside done so stale bits never pass as data
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
      hold_r <= 11'h000;
      start_o <= 1'h0;
      done_o <= 1'h0;
      {data_o, parity_o, stop_o} <= 11'h000;
    end else begin
      start_o <= send_i && cnt_r == 4'h0;
      done_o <= cnt_r == 4'h1;
      {data_o, parity_o, stop_o} <= (cnt_r == 4'h1) ? hold_r : ~{data_o, parity_o, stop_o};
      if (send_i && cnt_r == 4'h0) begin
        cnt_r <= 4'h6;
        hold_r <= {data_i, parity_i, stop_i};
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/urxbs_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module urxbs_tb_top
  import urxbs_pkg::*;
;
  typedef struct packed {
    logic [2:0] sz;
    logic hi, lo;
    logic [8:0] d;
    logic p, s;
    logic [7:0] ed;
    logic e9, efe, eupe;
  } urxbs_row_s;
  urxbs_row_s rows [7] = '{
    '{URXBS_SIZE_5, 1'h0, 1'h0, 9'h1FF, 1'h0, 1'h1, 8'h1F, 1'h0, 1'h0, 1'h0},
    '{URXBS_SIZE_6, 1'h1, 1'h0, 9'h0FF, 1'h1, 1'h1, 8'h3F, 1'h0, 1'h0, 1'h1},
    '{URXBS_SIZE_7, 1'h1, 1'h1, 9'h055, 1'h1, 1'h0, 8'h55, 1'h0, 1'h1, 1'h0},
    '{URXBS_SIZE_8, 1'h1, 1'h0, 9'h0A5, 1'h0, 1'h1, 8'hA5, 1'h0, 1'h0, 1'h0},
    '{URXBS_SIZE_9, 1'h1, 1'h1, 9'h1A5, 1'h0, 1'h1, 8'hA5, 1'h1, 1'h0, 1'h0},
    '{URXBS_SIZE_8, 1'h0, 1'h1, 9'h0C3, 1'h1, 1'h0, 8'hC3, 1'h0, 1'h1, 1'h0},
    '{URXBS_SIZE_5, 1'h1, 1'h1, 9'h003, 1'h0, 1'h1, 8'h03, 1'h0, 1'h0, 1'h1}
  };
  logic clock_i = 1'h0;
  logic rst_i = 1'h1;
  logic en = 1'h0, cie = 1'h0, gie = 1'h0, pmh = 1'h0, pml = 1'h0, rd = 1'h0;
  logic send = 1'h0, fp = 1'h0, fs = 1'h1;
  logic [2:0] sz = URXBS_SIZE_8;
  logic [8:0] fd = 9'h000;
  logic start, done, fpar, fstop, flag, fe, dor, upe, b9, irq, ovr;
  logic [8:0] fdata;
  logic [7:0] dat;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int drains = 0;

  always #2.5 clock_i = ~clock_i;

  urxbs_far_model far (.clock_i(clock_i), .rst_i(rst_i), .send_i(send), .data_i(fd), .parity_i(fp),
    .stop_i(fs), .start_o(start), .done_o(done), .data_o(fdata), .parity_o(fpar), .stop_o(fstop));

  urxbs_top dut (.clock_i(clock_i), .rst_i(rst_i), .rx_enable_bit_i(en), .rx_complete_irq_enable_i(cie),
    .global_irq_enable_i(gie), .parity_mode_high_bit_i(pmh), .parity_mode_low_bit_i(pml),
    .char_size_i(sz), .start_detect_i(start), .frame_done_i(done), .frame_data_i(fdata),
    .frame_parity_i(fpar), .frame_stop_i(fstop), .data_read_i(rd), .rx_complete_flag_o(flag),
    .frame_error_flag_o(fe), .overrun_flag_o(dor), .parity_error_flag_o(upe), .serial_data_o(dat),
    .rx_ninth_bit_o(b9), .rx_irq_o(irq), .rx_pin_override_o(ovr));

  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp1(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // partner answers a fixed 6 cycles after its start pulse
  task automatic send_frame(input logic [8:0] d, input logic p, input logic s);
    @(posedge clock_i);
    send <= 1'h1;
    fd <= d;
    fp <= p;
    fs <= s;
    @(posedge clock_i);
    send <= 1'h0;
    repeat (8) @(posedge clock_i);
    @(negedge clock_i);
  endtask

  task automatic read_data();
    @(posedge clock_i);
    rd <= 1'h1;
    @(posedge clock_i);
    rd <= 1'h0;
    repeat (2) @(negedge clock_i);
  endtask

  task automatic head(input logic [7:0] d, input logic o);
    cmp1(flag, 1'h1, "flag");
    cmp8(dat, d, "data");
    cmp1(dor, o, "overrun");
  endtask

  always @(posedge clock_i) begin
    cycles++;
    // the whole run needs some 215 cycles
    if (cycles == 2000) begin
      failures++;
      $display("MISMATCH %0t timeout", $time);
      close_out();
    end
  end

  initial begin
    repeat (9) @(posedge clock_i);
    @(negedge clock_i);
    cmp1(flag | irq | ovr, 1'h0, "reset outputs");
    @(posedge clock_i);
    rst_i <= 1'h0;
    en <= 1'h1;
    cie <= 1'h1;
    gie <= 1'h1;
    repeat (2) @(negedge clock_i);
    cmp1(ovr, 1'h1, "pin override");
    cmp1(flag | irq, 1'h0, "idle after reset");
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clock_i);
      sz <= rows[i].sz;
      pmh <= rows[i].hi;
      pml <= rows[i].lo;
      send_frame(rows[i].d, rows[i].p, rows[i].s);
      cmp1(irq, 1'h1, "irq");
      cmp8(dat, rows[i].ed, "data");
      cmp1(b9, rows[i].e9, "ninth");
      cmp1(fe, rows[i].efe, "frame err");
      cmp1(upe, rows[i].eupe, "parity err");
      head(rows[i].ed, 1'h0);
      read_data();
      cmp1(flag | irq, 1'h0, "after read");
    end
    $display("test rows done");
    // last row left 5-bit frames with odd parity; later bytes need all eight bits
    @(posedge clock_i);
    sz <= URXBS_SIZE_8;
    pmh <= 1'h0;
    pml <= 1'h0;
    read_data();
    send_frame(9'h011, 1'h0, 1'h1);
    send_frame(9'h022, 1'h0, 1'h1);
    send_frame(9'h033, 1'h0, 1'h1);
    send_frame(9'h044, 1'h0, 1'h1);
    head(8'h11, 1'h0);
    read_data();
    head(8'h22, 1'h0);
    read_data();
    head(8'h44, 1'h1);
    read_data();
    send_frame(9'h055, 1'h0, 1'h1);
    head(8'h55, 1'h0);
    $display("test overrun done");
    @(posedge clock_i);
    gie <= 1'h0;
    repeat (2) @(negedge clock_i);
    cmp1(irq, 1'h0, "irq global off");
    @(posedge clock_i);
    gie <= 1'h1;
    cie <= 1'h0;
    repeat (2) @(negedge clock_i);
    cmp1(irq, 1'h0, "irq local off");
    cmp1(flag, 1'h1, "flag held");
    @(posedge clock_i);
    cie <= 1'h1;
    $display("test irq done");
    @(posedge clock_i);
    send <= 1'h1;
    fd <= 9'h066;
    @(posedge clock_i);
    send <= 1'h0;
    repeat (2) @(posedge clock_i);
    en <= 1'h0;
    @(posedge clock_i);
    @(negedge clock_i);
    cmp1(flag | irq | ovr, 1'h0, "disable flush");
    @(posedge clock_i);
    en <= 1'h1;
    repeat (6) @(negedge clock_i);
    cmp1(flag, 1'h0, "dropped frame");
    cmp1(ovr, 1'h1, "pin back");
    $display("test disable done");
    send_frame(9'h077, 1'h0, 1'h1);
    send_frame(9'h088, 1'h0, 1'h1);
    head(8'h77, 1'h0);
    cmp1(fe | upe, 1'h0, "status before data");
    // software drain: read until the flag drops, bounded against a stuck flag
    while (flag && drains < 4) begin
      read_data();
      drains++;
    end
    cmp8(8'(drains), 8'h02, "drain reads");
    $display("test drain done");
    close_out();
  end
endmodule
`default_nettype wire
